// ### pacc_pkg.sv
//----------------------------------------------------------------------
// pulse accumulator and pin-function package
//----------------------------------------------------------------------
// Summary of operation
// - 16-bit accumulator, mode bit picks edge counting or gated time counting.
// - gated mode counts divide-by-64 ticks, never pin edges.
// - edge mode: each active edge adds one; polarity picks rising or falling.
// - edge mode: active edge sets input flag; enable gates its request.
// - wrap from ffff to zero sets overflow flag; enable gates its request.
// - edge counting works even with the timer disabled.
// - gated mode: ticks count only while pin sits at active level.
// - gated mode: trailing edge of active level sets input flag.
// - divide-by-64 ticks come from prescaler; none while timer inactive.
// - a timer pin is a port pin unless a timer function claims it.
// - timer disabled: pin is pure port pin steered by direction bit.
// - capture pin with zero edge field is a plain port pin.
// - capture pin set as output drives data latch and captures that value.
// - compare pin with zero action and clear ch3 mask bit stays under direction and data control.
// - nonzero action forces compare pin output, driven by compare events.
// - ch3 mask forces compare pins output; no effect on capture pins.
// - ch3 compare drives masked pins with ch3 data until own next compare.
// - port read gives pin level for inputs, data latch for outputs.
// - input flag stays set until software writes one to it.
package pacc_pkg;
    localparam int CNT_W = 16;
    localparam int NCH = 4;
    localparam int PAI_CH = 3;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam int PRESC_DIV = 64;
    // register offsets
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_FLAG = 4'h1;
    localparam logic [3:0] A_CNT = 4'h2;
    localparam logic [3:0] A_IOS = 4'h3;
    localparam logic [3:0] A_EDGE = 4'h4;
    localparam logic [3:0] A_ACT = 4'h5;
    localparam logic [3:0] A_MASK = 4'h6;
    localparam logic [3:0] A_ODAT = 4'h7;
    localparam logic [3:0] A_DDR = 4'h8;
    localparam logic [3:0] A_PORT = 4'h9;
    localparam logic [3:0] A_EVT = 4'ha;
    // control register fields
    localparam int B_TEN = 0;
    localparam int B_MODE = 1;
    localparam int B_POL = 2;
    localparam int B_IIE = 3;
    localparam int B_OIE = 4;
    // flag register fields
    localparam int B_IF = 0;
    localparam int B_OF = 1;
endpackage : pacc_pkg

// ### pacc_top.sv
`timescale 1ns/10ps
module pacc_top
#(
    parameter int CNT_W = pacc_pkg::CNT_W,
    parameter int NCH = pacc_pkg::NCH,
    parameter int PRESC_DIV = pacc_pkg::PRESC_DIV
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // compare events from the channel core, one-cycle pulses
    input wire logic [NCH-1:0] cmp_evt_i,
    // timer pins
    input wire logic [NCH-1:0] pin_in_i,
    output logic [NCH-1:0] pin_out_o,
    output logic [NCH-1:0] pin_oe_o,
    // capture edge sources and requests
    output logic [NCH-1:0] cap_src_o,
    output logic [NCH-1:0] cap_en_o,
    output logic accum_input_irq_o,
    output logic accum_overflow_irq_o
);

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [4:0] ctrl_reg;
    logic accum_input_flag_reg;
    logic accum_overflow_flag_reg;
    logic [CNT_W-1:0] accum_count_value_reg;
    logic [NCH-1:0] capture_compare_select_reg;
    logic [2*NCH-1:0] capture_edge_control_reg;
    logic [2*NCH-1:0] output_action_control_reg;
    logic [NCH-1:0] ch3_override_mask_reg;
    logic [NCH-1:0] ch3_override_data_reg;
    logic [NCH-1:0] ddr_reg;
    logic [NCH-1:0] port_latch_reg;
    logic [NCH-1:0] oc_level_reg;
    logic [NCH-1:0] ovr_active_reg;
    logic [NCH-1:0] sync1_reg;
    logic [NCH-1:0] sync2_reg;
    logic pai_prev_reg;
    logic [5:0] presc_reg;
    logic [15:0] rdata_reg;

    wire timer_enable_bit = ctrl_reg[pacc_pkg::B_TEN];
    wire accum_mode_select = ctrl_reg[pacc_pkg::B_MODE];
    wire accum_polarity_select = ctrl_reg[pacc_pkg::B_POL];
    wire accum_input_irq_enable = ctrl_reg[pacc_pkg::B_IIE];
    wire accum_overflow_irq_enable = ctrl_reg[pacc_pkg::B_OIE];

    //------------------------------------------------------------------
    // register decode
    //------------------------------------------------------------------
    wire wr_ctrl = ce_i && wr_i && addr_i == pacc_pkg::A_CTRL;
    wire wr_flag = ce_i && wr_i && addr_i == pacc_pkg::A_FLAG;
    wire wr_cnt = ce_i && wr_i && addr_i == pacc_pkg::A_CNT;
    wire wr_ios = ce_i && wr_i && addr_i == pacc_pkg::A_IOS;
    wire wr_edge = ce_i && wr_i && addr_i == pacc_pkg::A_EDGE;
    wire wr_act = ce_i && wr_i && addr_i == pacc_pkg::A_ACT;
    wire wr_mask = ce_i && wr_i && addr_i == pacc_pkg::A_MASK;
    wire wr_odat = ce_i && wr_i && addr_i == pacc_pkg::A_ODAT;
    wire wr_ddr = ce_i && wr_i && addr_i == pacc_pkg::A_DDR;
    wire wr_port = ce_i && wr_i && addr_i == pacc_pkg::A_PORT;

    //------------------------------------------------------------------
    // accumulator input: synchronised pin 3
    //------------------------------------------------------------------
    // the pin must hold its level across at least one clock edge or the edge is missed
    wire pai_now = sync2_reg[pacc_pkg::PAI_CH];
    wire pai_active = pai_now == accum_polarity_select;
    wire pai_prev_active = pai_prev_reg == accum_polarity_select;
    wire active_edge = pai_active && !pai_prev_active;
    wire trailing_edge = !pai_active && pai_prev_active;

    // prescaler runs only while the timer is enabled
    wire presc_tick = timer_enable_bit && presc_reg == 6'(PRESC_DIV - 1);

    // edge mode ignores the timer enable
    wire cnt_edge = !accum_mode_select && active_edge;
    // gated mode counts prescaler ticks only at the active level
    wire cnt_gate = accum_mode_select && presc_tick && pai_active;
    wire cnt_inc = cnt_edge || cnt_gate;
    wire cnt_wrap = cnt_inc && accum_count_value_reg == CNT_W'(pacc_pkg::CNT_MAX);
    // edge mode sets on the active edge, gated mode on the trailing one
    wire if_set = accum_mode_select ? trailing_edge : active_edge;

    // set wins over a write-one clear
    wire if_next = if_set || (accum_input_flag_reg && !(wr_flag && wdata_i[pacc_pkg::B_IF]));
    wire of_next = cnt_wrap ||
        (accum_overflow_flag_reg && !(wr_flag && wdata_i[pacc_pkg::B_OF]));

    //------------------------------------------------------------------
    // pin functions
    //------------------------------------------------------------------
    logic [NCH-1:0] act_nz;
    logic [NCH-1:0] edge_nz;
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_act
            assign act_nz[g] = |output_action_control_reg[2*g+1:2*g];
            assign edge_nz[g] = |capture_edge_control_reg[2*g+1:2*g];
        end
    endgenerate

    wire [NCH-1:0] sel_cmp = capture_compare_select_reg & {NCH{timer_enable_bit}};
    // mask only matters for compare-selected pins
    wire [NCH-1:0] masked = sel_cmp & ch3_override_mask_reg;
    // compare owns the pin; direction bit is untouched
    wire [NCH-1:0] oc_owns = (sel_cmp & act_nz) | masked;
    // everything else is a port pin
    wire [NCH-1:0] oe_next = oc_owns | ddr_reg;
    wire [NCH-1:0] oc_drive = ovr_active_reg & masked;
    wire [NCH-1:0] out_next = (oc_owns & ((oc_drive & ch3_override_data_reg) |
        (~oc_drive & oc_level_reg))) | (~oc_owns & port_latch_reg);
    // inputs read the pin, outputs read the latch
    wire [NCH-1:0] port_read = (ddr_reg & port_latch_reg) | (~ddr_reg & sync2_reg);
    wire ch3_evt = cmp_evt_i[pacc_pkg::PAI_CH] && sel_cmp[pacc_pkg::PAI_CH];

    // compare action: 01 toggle, 10 clear, 11 set
    function automatic logic oc_apply(input logic [1:0] act, input logic cur);
        case (act)
            2'h1: oc_apply = !cur;
            2'h2: oc_apply = 1'b0;
            2'h3: oc_apply = 1'b1;
            default: oc_apply = cur;
        endcase
    endfunction : oc_apply

    logic [NCH-1:0] oc_level_next;
    logic [NCH-1:0] ovr_next;
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            oc_level_next[i] = oc_level_reg[i];
            ovr_next[i] = ovr_active_reg[i];
            // own compare resumes driving its pin after a ch3 override
            if (cmp_evt_i[i] && sel_cmp[i])
            begin
                oc_level_next[i] = oc_apply(output_action_control_reg[2*i+:2],
                    oc_level_reg[i]);
                ovr_next[i] = 1'b0;
            end
            if (ch3_evt && masked[i])
            begin
                ovr_next[i] = 1'b1;
            end
        end
    end

    //------------------------------------------------------------------
    // read mux
    //------------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        case (addr_i)
            pacc_pkg::A_CTRL: rd_mux = {11'h000, ctrl_reg};
            pacc_pkg::A_FLAG: rd_mux = {14'h0000, accum_overflow_flag_reg, accum_input_flag_reg};
            pacc_pkg::A_CNT: rd_mux = 16'(accum_count_value_reg);
            pacc_pkg::A_IOS: rd_mux = 16'(capture_compare_select_reg);
            pacc_pkg::A_EDGE: rd_mux = 16'(capture_edge_control_reg);
            pacc_pkg::A_ACT: rd_mux = 16'(output_action_control_reg);
            pacc_pkg::A_MASK: rd_mux = 16'(ch3_override_mask_reg);
            pacc_pkg::A_ODAT: rd_mux = 16'(ch3_override_data_reg);
            pacc_pkg::A_DDR: rd_mux = 16'(ddr_reg);
            pacc_pkg::A_PORT: rd_mux = 16'(port_read);
            default: rd_mux = 16'h0000;
        endcase
    end

    //------------------------------------------------------------------
    // sequential logic
    //------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            pai_prev_reg <= 1'b0;
            presc_reg <= 6'h00;
        end
        else if (ce_i)
        begin
            sync1_reg <= pin_in_i;
            sync2_reg <= sync1_reg;
            pai_prev_reg <= pai_now;
            presc_reg <= (!timer_enable_bit || presc_tick) ? 6'h00 : presc_reg + 6'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            accum_count_value_reg <= CNT_W'(pacc_pkg::CNT_RST);
            accum_input_flag_reg <= 1'b0;
            accum_overflow_flag_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_cnt)
                accum_count_value_reg <= CNT_W'(wdata_i);
            else if (cnt_inc)
                accum_count_value_reg <= accum_count_value_reg + CNT_W'(1);
            accum_input_flag_reg <= if_next;
            accum_overflow_flag_reg <= of_next;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_reg <= 5'h00;
            capture_compare_select_reg <= '0;
            capture_edge_control_reg <= '0;
            output_action_control_reg <= '0;
            ch3_override_mask_reg <= '0;
            ch3_override_data_reg <= '0;
            ddr_reg <= '0;
            port_latch_reg <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= wdata_i[4:0];
            if (wr_ios)
                capture_compare_select_reg <= wdata_i[NCH-1:0];
            if (wr_edge)
                capture_edge_control_reg <= wdata_i[2*NCH-1:0];
            if (wr_act)
                output_action_control_reg <= wdata_i[2*NCH-1:0];
            if (wr_mask)
                ch3_override_mask_reg <= wdata_i[NCH-1:0];
            if (wr_odat)
                ch3_override_data_reg <= wdata_i[NCH-1:0];
            if (wr_ddr)
                ddr_reg <= wdata_i[NCH-1:0];
            // writes to a compare-owned pin only reach the latch
            if (wr_port)
                port_latch_reg <= wdata_i[NCH-1:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            oc_level_reg <= '0;
            ovr_active_reg <= '0;
            pin_out_o <= '0;
            pin_oe_o <= '0;
            rdata_reg <= 16'h0000;
        end
        else if (ce_i)
        begin
            oc_level_reg <= oc_level_next;
            ovr_active_reg <= ovr_next;
            pin_out_o <= out_next;
            pin_oe_o <= oe_next;
            rdata_reg <= rd_i ? rd_mux : 16'h0000;
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign rdata_o = rdata_reg;
    // a capture pin set as output sees its own driven value
    assign cap_src_o = (ddr_reg & port_latch_reg) | (~ddr_reg & sync2_reg);
    assign cap_en_o = ~capture_compare_select_reg & edge_nz & {NCH{timer_enable_bit}};
    assign accum_input_irq_o = accum_input_flag_reg && accum_input_irq_enable;
    assign accum_overflow_irq_o = accum_overflow_flag_reg && accum_overflow_irq_enable;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    edge_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && cnt_edge && !wr_cnt |=> accum_count_value_reg ==
            $past(accum_count_value_reg) + CNT_W'(1))
        else $error("edge did not add one");
    edge_no_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !accum_mode_select && active_edge && !timer_enable_bit && !wr_cnt
            |=> accum_count_value_reg != $past(accum_count_value_reg))
        else $error("edge count blocked by timer enable");
    gate_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accum_mode_select && !timer_enable_bit && !wr_cnt
            |=> $stable(accum_count_value_reg))
        else $error("gated count without timer");
    gate_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accum_mode_select && !pai_active && !wr_cnt
            |=> $stable(accum_count_value_reg))
        else $error("gated count at inactive level");
    wrap_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && cnt_wrap && !wr_cnt |=> accum_overflow_flag_reg &&
            accum_count_value_reg == CNT_W'(pacc_pkg::CNT_RST))
        else $error("wrap did not set overflow");
    trail_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accum_mode_select && trailing_edge |=> accum_input_flag_reg)
        else $error("trailing edge missed");
    flag_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accum_input_flag_reg && !(wr_flag && wdata_i[pacc_pkg::B_IF]) |=> accum_input_flag_reg)
        else $error("input flag dropped");
    port_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !timer_enable_bit |=> pin_oe_o == $past(ddr_reg) &&
            pin_out_o == $past(port_latch_reg))
        else $error("disabled pin not a port pin");
    oc_force_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && (sel_cmp & act_nz) != '0 |=> (pin_oe_o & $past(sel_cmp & act_nz))
            == $past(sel_cmp & act_nz))
        else $error("compare pin not forced out");
    read_back_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && rd_i && addr_i == pacc_pkg::A_PORT |=> rdata_o == 16'($past(port_read)))
        else $error("port read wrong");

    //------------------------------------------------------------------
    // assertions: flags, gating and pin ownership
    //------------------------------------------------------------------
    edge_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !accum_mode_select && active_edge |=> accum_input_flag_reg)
        else $error("active edge did not set input flag");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_flag && wdata_i[pacc_pkg::B_IF] && !if_set |=> !accum_input_flag_reg)
        else $error("write one did not clear input flag");
    ovf_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accum_overflow_flag_reg && !(wr_flag && wdata_i[pacc_pkg::B_OF]) |=> accum_overflow_flag_reg)
        else $error("overflow flag dropped");
    gate_tick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accum_mode_select && presc_tick && pai_active && !wr_cnt
            |=> accum_count_value_reg == $past(accum_count_value_reg) + CNT_W'(1))
        else $error("gated tick did not add one");
    gate_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && accum_mode_select && !presc_tick && !wr_cnt
            |=> $stable(accum_count_value_reg))
        else $error("gated count moved without a tick");
    ce_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(accum_count_value_reg) && $stable(pin_out_o) && $stable(pin_oe_o))
        else $error("state moved while clock enable low");
    ovr_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && ch3_evt |=> (ovr_active_reg & $past(masked)) == $past(masked))
        else $error("ch3 compare did not override masked pins");
    own_resume_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && (cmp_evt_i & sel_cmp & ~(masked & {NCH{ch3_evt}})) != '0
            |=> (ovr_active_reg & $past(cmp_evt_i & sel_cmp & ~(masked & {NCH{ch3_evt}})))
            == '0)
        else $error("own compare did not end override");
    mask_oe_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && masked != '0 |=> (pin_oe_o & $past(masked)) == $past(masked))
        else $error("masked compare pin not forced out");
    port_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> (pin_oe_o & ~$past(oc_owns)) == ($past(ddr_reg) & ~$past(oc_owns)))
        else $error("free pin not under direction bit");
    port_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> (pin_out_o & ~$past(oc_owns)) == ($past(port_latch_reg) & ~$past(oc_owns)))
        else $error("free pin not driven from data latch");

endmodule : pacc_top

// ### pacc_pin_src.sv
`timescale 1ns/10ps
module pacc_pin_src
(
    // clock
    input wire logic clk_i,
    // design pin drive
    input wire logic [3:0] pin_out_i,
    input wire logic [3:0] pin_oe_i,
    // resolved pin levels
    output logic [3:0] pin_o
);
    logic [3:0] ext_reg;

    // a driven pin shows the design's value, an undriven one the source level
    assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_reg);

    initial ext_reg = 4'h0;

    //------------------------------------------------------------------
    // external source
    //------------------------------------------------------------------
    task automatic set_level(input logic [2:0] lvl);
        @(posedge clk_i);
        ext_reg[2:0] <= lvl;
    endtask : set_level

    // each phase held at least three clocks so the synchroniser sees it
    task automatic pulse(input int hold);
        int h;
        h = (hold < 3) ? 3 : hold;
        @(posedge clk_i);
        ext_reg[3] <= ~ext_reg[3];
        repeat (h) @(posedge clk_i);
        ext_reg[3] <= ~ext_reg[3];
        repeat (h) @(posedge clk_i);
    endtask : pulse
endmodule : pacc_pin_src

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk_i, rst_n_i;
    logic [3:0] addr_i;
    logic [15:0] wdata_i, rdata_o, rv;
    logic wr_i, rd_i, in_irq, ov_irq, b0, ce;
    logic [3:0] cmp_evt_i, pin_in, pin_out, pin_oe, cap_src, cap_en;
    int fails, checks_done, i;

    pacc_top u_pacc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cmp_evt_i(cmp_evt_i), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .cap_src_o(cap_src), .cap_en_o(cap_en), .accum_input_irq_o(in_irq),
        .accum_overflow_irq_o(ov_irq));
    pacc_pin_src u_pacc_pin_src (.clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .pin_o(pin_in));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    //------------------------------------------------------------------
    // bus and check tasks
    //------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic cmp(input logic [3:0] m);
        @(posedge clk_i);
        cmp_evt_i <= m;
        @(posedge clk_i);
        cmp_evt_i <= 4'h0;
        tick(2);
    endtask : cmp

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results;
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        results();
    end

    //------------------------------------------------------------------
    // tests
    //------------------------------------------------------------------
    initial
    begin
        rst_n_i = 1'b0;
        {wr_i, rd_i, addr_i, wdata_i, cmp_evt_i} = '0;
        ce = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // pin 3 kept free of output logic while it feeds the accumulator
        rd(pacc_pkg::A_CNT, rv); check("cnt rst", rv, 16'h0000);
        rd(pacc_pkg::A_FLAG, rv); check("flag rst", rv, 16'h0000);
        // edge mode, rising, timer disabled
        wr(pacc_pkg::A_CTRL, 16'h0004);
        for (i = 0; i < 3; i++)
            u_pacc_pin_src.pulse(3);
        tick(4);
        rd(pacc_pkg::A_CNT, rv); check("cnt rise", rv, 16'h0003);
        rd(pacc_pkg::A_FLAG, rv); check("in flag", rv, 16'h0001);
        check("irq masked", {15'h0, in_irq}, 16'h0000);
        wr(pacc_pkg::A_CTRL, 16'h000c);
        tick(1);
        check("irq on", {15'h0, in_irq}, 16'h0001);
        wr(pacc_pkg::A_FLAG, 16'h0000);
        rd(pacc_pkg::A_FLAG, rv); check("w0 keeps", rv, 16'h0001);
        wr(pacc_pkg::A_FLAG, 16'h0001);
        rd(pacc_pkg::A_FLAG, rv); check("w1 clears", rv, 16'h0000);
        // falling polarity and wrap
        wr(pacc_pkg::A_CTRL, 16'h0010);
        wr(pacc_pkg::A_CNT, 16'hffff);
        u_pacc_pin_src.pulse(4);
        tick(4);
        rd(pacc_pkg::A_CNT, rv); check("wrap cnt", rv, 16'h0000);
        rd(pacc_pkg::A_FLAG, rv); check("ovf flag", rv, 16'h0003);
        check("ovf irq", {15'h0, ov_irq}, 16'h0001);
        // clock enable low: a pin edge is lost and the count holds
        @(posedge clk_i);
        ce <= 1'b0;
        u_pacc_pin_src.pulse(4);
        @(posedge clk_i);
        ce <= 1'b1;
        tick(4);
        rd(pacc_pkg::A_CNT, rv); check("ce freeze", rv, 16'h0000);
        rd(pacc_pkg::A_FLAG, rv); check("flags kept", rv, 16'h0003);
        // gated mode, timer off: no ticks
        wr(pacc_pkg::A_FLAG, 16'h0003);
        wr(pacc_pkg::A_CTRL, 16'h0006);
        u_pacc_pin_src.pulse(200);
        tick(4);
        rd(pacc_pkg::A_CNT, rv); check("gate ten0", rv, 16'h0000);
        // gated mode, timer on: exactly ten ticks over 640 clocks
        wr(pacc_pkg::A_CTRL, 16'h0007);
        wr(pacc_pkg::A_FLAG, 16'h0003);
        u_pacc_pin_src.pulse(640);
        tick(4);
        // 640 clocks at the active level hold exactly ten divide-by-64 ticks
        rd(pacc_pkg::A_CNT, rv);
        check("gate ticks", rv, 16'h000a);
        rd(pacc_pkg::A_FLAG, rv); check("trail flag", rv, 16'h0001);
        // port pins, timer off
        wr(pacc_pkg::A_CTRL, 16'h0000);
        wr(pacc_pkg::A_PORT, 16'h000a);
        wr(pacc_pkg::A_DDR, 16'h000f);
        tick(2);
        check("oe dir1", {12'h0, pin_oe}, 16'h000f);
        check("out dir1", {12'h0, pin_out}, 16'h000a);
        rd(pacc_pkg::A_PORT, rv); check("rd latch", rv, 16'h000a);
        wr(pacc_pkg::A_DDR, 16'h0000);
        u_pacc_pin_src.set_level(3'h5);
        tick(5);
        check("oe dir0", {12'h0, pin_oe}, 16'h0000);
        rd(pacc_pkg::A_PORT, rv); check("rd pin", rv, 16'h0005);
        // capture pins
        wr(pacc_pkg::A_CTRL, 16'h0001);
        wr(pacc_pkg::A_DDR, 16'h0003);
        tick(2);
        check("cap off", {12'h0, cap_en}, 16'h0000);
        check("cap oe", {12'h0, pin_oe}, 16'h0003);
        wr(pacc_pkg::A_EDGE, 16'h0055);
        tick(2);
        check("cap on", {12'h0, cap_en}, 16'h000f);
        check("cap src", {14'h0, cap_src[1:0]}, 16'h0002);
        check("cap out", {14'h0, pin_out[1:0]}, 16'h0002);
        // compare pins
        wr(pacc_pkg::A_IOS, 16'h000f);
        wr(pacc_pkg::A_DDR, 16'h0000);
        tick(2);
        check("cmp act0", {12'h0, pin_oe}, 16'h0000);
        wr(pacc_pkg::A_ACT, 16'h0009);
        tick(2);
        check("cmp oe", {12'h0, pin_oe}, 16'h0003);
        rd(pacc_pkg::A_DDR, rv); check("ddr kept", rv, 16'h0000);
        b0 = pin_out[0];
        cmp(4'h1);
        check("toggle", {15'h0, pin_out[0]}, {15'h0, ~b0});
        // ch3 override on masked compare pin 1
        wr(pacc_pkg::A_ACT, 16'h0001);
        wr(pacc_pkg::A_MASK, 16'h0002);
        wr(pacc_pkg::A_ODAT, 16'h0002);
        tick(2);
        check("mask oe", {14'h0, pin_oe[1:0]}, 16'h0003);
        cmp(4'h8);
        check("ovr data", {15'h0, pin_out[1]}, 16'h0001);
        wr(pacc_pkg::A_ACT, 16'h0009);
        cmp(4'h2);
        check("own cmp", {15'h0, pin_out[1]}, 16'h0000);
        wr(pacc_pkg::A_ACT, 16'h000d);
        cmp(4'h2);
        check("set act", {15'h0, pin_out[1]}, 16'h0001);
        wr(pacc_pkg::A_IOS, 16'h000b);
        wr(pacc_pkg::A_MASK, 16'h0004);
        tick(2);
        check("mask cap", {15'h0, pin_oe[2]}, 16'h0000);
        results();
    end
endmodule : tb_top
